// *** csf_defs.svh ***
// constants for the cpu status flag logic: offsets, fields, resets
// assumes a plain register port with word indices
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

// register indices on the plain register port
`define CSF_ADDR_STATUS    4'h0
`define CSF_ADDR_CORE      4'h1
`define CSF_ADDR_INTCTL    4'h2
`define CSF_ADDR_LEVEL     4'h3

// status word field positions
`define CSF_BIT_HALF       8
`define CSF_BIT_PRIO_HI    7
`define CSF_BIT_PRIO_LO    5
`define CSF_BIT_REPEAT     4
`define CSF_BIT_NEG        3
`define CSF_BIT_WRAP       2
`define CSF_BIT_ZERO       1
`define CSF_BIT_CARRY      0

// core control and interrupt control fields
`define CSF_BIT_PRIO_TOP   3
`define CSF_BIT_NEST_DIS   15

// reset values and the priority field value for user interrupts off
`define CSF_RST_PRIO       3'h0
`define CSF_RST_FLAGS      5'h00
`define CSF_PRIO_ALL_OFF   3'h7

`endif

// *** csf_pkg.sv ***
// types shared by the cpu status flag logic
// assumes csf_defs.svh supplies the register offsets and field positions; enum codes are set here
package csf_pkg;

    // operand size of an arithmetic update
    typedef enum logic [0:0] {
        CSF_SZ_WORD = 1'b0,
        CSF_SZ_BYTE = 1'b1
    } csf_size_t;

    // kind of arithmetic operation
    typedef enum logic [1:0] {
        CSF_OP_ADD  = 2'b00,
        CSF_OP_SUB  = 2'b01,
        CSF_OP_PASS = 2'b10
    } csf_op_t;

    // which flags an instruction may touch
    typedef struct packed {
        logic half;
        logic neg;
        logic wrap;
        logic zero;
        logic carry;
    } csf_flag_set_t;

endpackage

// *** csf_alu_if.sv ***
// carrier between the flag calculator and the status register top
// assumes one clock domain shared by both sides
`timescale 1ns/1ps
interface csf_alu_if;
    import csf_pkg::*;
    csf_flag_set_t flags;     // computed flag values
    logic          is_zero;   // result equal to zero
    modport calc (output flags, output is_zero);
    modport user (input  flags, input  is_zero);
endinterface

// *** csf_flag_calc.sv ***
// arithmetic flag calculator for byte or word operations
// assumes operands arrive from the datapath on the core clock
`timescale 1ns/1ps
module csf_flag_calc
    import csf_pkg::*;
(
    input  wire logic [15:0] opnd_a,
    input  wire logic [15:0] opnd_b,
    input  wire logic        carry_in,
    input  wire csf_op_t     op_kind,
    input  wire csf_size_t   op_size,
    csf_alu_if.calc          res
);
    logic [15:0] b_eff;
    logic        cin_eff;
    logic [16:0] sum;
    logic [8:0]  low_sum;
    logic [4:0]  nib_sum;
    logic        sign_a;
    logic        sign_b;
    logic        sign_r;
    logic        c_msb;

    // ***************************************************
    // adder: subtraction as a plus inverted b plus one
    // ***************************************************
    always_comb
    begin
        b_eff   = (op_kind == CSF_OP_SUB) ? ~opnd_b : opnd_b;
        cin_eff = (op_kind == CSF_OP_PASS) ? 1'b0 : carry_in;
        if (op_kind == CSF_OP_PASS)
        begin
            b_eff = 16'h0000;
        end
        sum     = {1'b0, opnd_a} + {1'b0, b_eff} + {16'h0000, cin_eff};
        low_sum = {1'b0, opnd_a[7:0]} + {1'b0, b_eff[7:0]}
                  + {8'h00, cin_eff};
        nib_sum = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]}
                  + {4'h0, cin_eff};
    end

    // flags differ by operand size
    always_comb
    begin
        if (op_size == CSF_SZ_BYTE)
        begin
            sign_a          = opnd_a[7];
            sign_b          = b_eff[7];
            sign_r          = low_sum[7];
            c_msb           = low_sum[8];
            res.flags.half  = nib_sum[4];
            res.is_zero     = (low_sum[7:0] == 8'h00);
        end
        else
        begin
            sign_a          = opnd_a[15];
            sign_b          = b_eff[15];
            sign_r          = sum[15];
            c_msb           = sum[16];
            res.flags.half  = low_sum[8];
            res.is_zero     = (sum[15:0] == 16'h0000);
        end
        res.flags.neg   = sign_r;
        res.flags.wrap  = (sign_a == sign_b) && (sign_r != sign_a);
        res.flags.carry = c_msb;
        res.flags.zero  = res.is_zero;
    end
endmodule // csf_flag_calc

// *** csf_status_top.sv ***
// cpu status word with arithmetic flags and priority level
// assumes datapath and software share one clock and sync reset
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "csf_defs.svh"

// Operation
// - half carry from bit 3 for bytes, bit 7 for words
// - three-bit priority field; 7 means user interrupts off
// - effective level is the top bit above the three-bit field
// - top bit set gives levels eight to fifteen
// - top bit set disables all user interrupts
// - nesting disable makes the priority field read only
// - repeat flag follows the repeat loop activity
// - negative flag follows result sign
// - wrap flag marks signed overflow
// - zero flag set by a zero result, cleared by a non-zero result
// - carry flag marks carry out of the top bit
module csf_status_top
    import csf_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire logic [3:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_write,
    input  wire logic          reg_read,
    output logic      [15:0]   reg_rdata,
    input  wire logic          upd_valid,
    input  wire logic [15:0]   opnd_a,
    input  wire logic [15:0]   opnd_b,
    input  wire csf_op_t       op_kind,
    input  wire csf_size_t     op_size,
    input  wire csf_flag_set_t upd_mask,
    input  wire logic          use_carry,
    input  wire logic          repeat_busy,
    output logic      [3:0]    priority_level,
    output logic               user_int_off
);
    // ***************************************************
    // state
    // ***************************************************
    logic [2:0]    prio_q;
    logic          prio_top_q;
    logic          nest_dis_q;
    logic          repeat_q;
    csf_flag_set_t flags_q;
    logic [15:0]   status_word;
    logic          wr_status;
    logic          carry_in;

    csf_alu_if alu ();

    // carry in from the held carry flag when chained
    assign carry_in = use_carry ? flags_q.carry :
                      (op_kind == CSF_OP_SUB);

    csf_flag_calc u_calc (
        .opnd_a   (opnd_a),
        .opnd_b   (opnd_b),
        .carry_in (carry_in),
        .op_kind  (op_kind),
        .op_size  (op_size),
        .res      (alu.calc)
    );

    assign wr_status = reg_write && (reg_addr == `CSF_ADDR_STATUS);

    // ***************************************************
    // arithmetic flags
    // ***************************************************
    // datapath update first, software write only when idle
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            flags_q <= `CSF_RST_FLAGS;
        end
        else if (upd_valid)
        begin
            if (upd_mask.half)
                flags_q.half <= alu.flags.half;
            if (upd_mask.neg)
                flags_q.neg <= alu.flags.neg;
            if (upd_mask.wrap)
                flags_q.wrap <= alu.flags.wrap;
            if (upd_mask.zero && !alu.is_zero)
                flags_q.zero <= 1'b0;
            else if (upd_mask.zero)
                flags_q.zero <= 1'b1;
            if (upd_mask.carry)
                flags_q.carry <= alu.flags.carry;
        end
        else if (wr_status)
        begin
            flags_q.half  <= reg_wdata[`CSF_BIT_HALF];
            flags_q.neg   <= reg_wdata[`CSF_BIT_NEG];
            flags_q.wrap  <= reg_wdata[`CSF_BIT_WRAP];
            flags_q.zero  <= reg_wdata[`CSF_BIT_ZERO];
            flags_q.carry <= reg_wdata[`CSF_BIT_CARRY];
        end
    end

    // ***************************************************
    // priority field and control bits
    // ***************************************************
    // priority field writable unless locked or beside a flag update
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            prio_q <= `CSF_RST_PRIO;
        end
        else if (wr_status && !upd_valid && !nest_dis_q)
        begin
            prio_q <= reg_wdata[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO];
        end
    end

    // core control top priority bit
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            prio_top_q <= 1'b0;
        else if (reg_write && (reg_addr == `CSF_ADDR_CORE))
            prio_top_q <= reg_wdata[`CSF_BIT_PRIO_TOP];
    end

    // interrupt control nesting disable bit
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            nest_dis_q <= 1'b0;
        else if (reg_write && (reg_addr == `CSF_ADDR_INTCTL))
            nest_dis_q <= reg_wdata[`CSF_BIT_NEST_DIS];
    end

    // repeat flag mirrors the loop sequencer, read only
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            repeat_q <= 1'b0;
        else
            repeat_q <= repeat_busy;
    end

    // ***************************************************
    // effective level and interrupt gate
    // ***************************************************
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            priority_level <= 4'h0;
            user_int_off   <= 1'b0;
        end
        else
        begin
            priority_level <= {prio_top_q, prio_q};
            user_int_off   <= prio_top_q
                              || (prio_q == `CSF_PRIO_ALL_OFF);
        end
    end

    // ***************************************************
    // read port: data in the cycle after the strobe
    // ***************************************************
    always_comb
    begin
        status_word                                     = 16'h0000;
        status_word[`CSF_BIT_HALF]                      = flags_q.half;
        status_word[`CSF_BIT_PRIO_HI:`CSF_BIT_PRIO_LO]  = prio_q;
        status_word[`CSF_BIT_REPEAT]                    = repeat_q;
        status_word[`CSF_BIT_NEG]                       = flags_q.neg;
        status_word[`CSF_BIT_WRAP]                      = flags_q.wrap;
        status_word[`CSF_BIT_ZERO]                      = flags_q.zero;
        status_word[`CSF_BIT_CARRY]                     = flags_q.carry;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            reg_rdata <= 16'h0000;
        else if (reg_read)
        begin
            unique case (reg_addr)
                `CSF_ADDR_STATUS: reg_rdata <= status_word;
                `CSF_ADDR_CORE:   reg_rdata <= {12'h000, prio_top_q, 3'h0};
                `CSF_ADDR_INTCTL: reg_rdata <= {nest_dis_q, 15'h0000};
                `CSF_ADDR_LEVEL:  reg_rdata <= {12'h000, prio_top_q, prio_q};
                default:          reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end
endmodule // csf_status_top

// *** csf_status_monitor.sv ***
// checker watching the status flag block at its top ports
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module csf_status_monitor
    import csf_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        upd_valid,
    input wire logic        repeat_busy,
    input wire logic [3:0]  priority_level,
    input wire logic        user_int_off
);
    // ****
    // clocking and shadow state
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic nest_q;

    // shadow of the nesting disable bit as software wrote it
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            nest_q <= 1'b0;
        else if (reg_write && reg_addr == 4'h2)
            nest_q <= reg_wdata[15];
    end

    // ****
    // properties
    // ****
    a_off_level: assert property (
        user_int_off == (priority_level[3] || &priority_level[2:0]))
        else $error("interrupt gate disagrees with level");
    a_top_blocks_all: assert property (
        reg_write && reg_addr == 4'h1 && reg_wdata[3] |-> ##2 user_int_off)
        else $error("top level bit did not gate interrupts");
    a_field_write: assert property (
        reg_write && reg_addr == 4'h0 && !upd_valid && !nest_q
        |-> ##2 priority_level[2:0] == $past(reg_wdata[7:5], 2))
        else $error("priority field write not seen on level");
    a_top_write: assert property (
        reg_write && reg_addr == 4'h1
        |-> ##2 priority_level[3] == $past(reg_wdata[3], 2))
        else $error("top level bit write not seen on level");
    a_nest_locks: assert property (
        reg_write && reg_addr == 4'h0 && nest_q
        |-> ##2 $stable(priority_level[2:0]))
        else $error("priority field changed while locked");
    a_update_wins: assert property (
        reg_write && reg_addr == 4'h0 && upd_valid
        |-> ##2 $stable(priority_level[2:0]))
        else $error("status write taken beside a flag update");
    a_repeat_read: assert property (
        $past(reg_read) && $past(reg_addr) == 4'h0
        |-> reg_rdata[4] == $past(repeat_busy, 2))
        else $error("repeat bit does not follow the loop");
    a_level_read: assert property (
        $past(reg_read) && $past(reg_addr) == 4'h3
        |-> reg_rdata == {12'h000, priority_level})
        else $error("effective level read disagrees");
endmodule // csf_status_monitor

bind csf_status_top csf_status_monitor mon (.clock(clock),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .upd_valid(upd_valid), .repeat_busy(repeat_busy),
    .priority_level(priority_level), .user_int_off(user_int_off));

// *** test_cpu_status_flag_logic.sv ***
// self-checking bench for the status flag block
// assumes csf_status_top with its checker bound in
`timescale 1ns/1ps
module test_cpu_status_flag_logic import csf_pkg::*;;
    logic          clock, reset_n, reg_write, reg_read, upd_valid;
    logic          repeat_busy, use_carry, user_int_off;
    logic [3:0]    reg_addr, priority_level;
    logic [15:0]   reg_wdata, reg_rdata, opnd_a, opnd_b;
    csf_op_t       op_kind;
    csf_size_t     op_size;
    csf_flag_set_t upd_mask;
    int            bad_count = 0;
    int            num_checks = 0;

    csf_status_top dut (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .upd_valid(upd_valid),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .op_kind(op_kind),
        .op_size(op_size), .upd_mask(upd_mask), .use_carry(use_carry),
        .repeat_busy(repeat_busy), .priority_level(priority_level),
        .user_int_off(user_int_off));

    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // one flag update, then the flag bits read back
    task automatic op(input logic [15:0] a, b, input csf_op_t k,
                      input csf_size_t s, input logic [4:0] m, e);
        @(posedge clock);
        opnd_a <= a;
        opnd_b <= b;
        op_kind <= k;
        op_size <= s;
        upd_mask <= m;
        upd_valid <= 1'b1;
        @(posedge clock);
        upd_valid <= 1'b0;
        rc(4'h0, {7'h00, e[4], 4'h0, e[3:0]});
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset;
        for (int a = 0; a < 4; a++)
            rc(4'(a), 16'h0000);
        wr(4'hF, 16'hFFFF);
        rc(4'hF, 16'h0000);
        chk({12'h000, priority_level}, 16'h0000);
        chk(16'(user_int_off), 16'h0000);
    endtask
    task automatic t_prio;
        for (int t = 0; t < 2; t++)
            for (int f = 0; f < 8; f++)
            begin
                wr(4'h1, 16'(t << 3));
                wr(4'h0, 16'(f << 5));
                rc(4'h3, 16'(t * 8 + f));
                chk({12'h000, priority_level}, 16'(t * 8 + f));
                chk(16'(user_int_off), 16'(t == 1 || f == 7));
            end
        wr(4'h1, 16'h0000);
    endtask
    task automatic t_nest;
        wr(4'h0, 16'h0060);
        wr(4'h2, 16'h8000);
        rc(4'h2, 16'h8000);
        wr(4'h0, 16'h00A0);
        rc(4'h0, 16'h0060);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h00A0);
        rc(4'h0, 16'h00A0);
    endtask
    task automatic t_repeat;
        @(posedge clock);
        repeat_busy <= 1'b1;
        wr(4'h0, 16'h0000);
        rc(4'h0, 16'h0010);
        @(posedge clock);
        repeat_busy <= 1'b0;
        wr(4'h0, 16'h0010);
        rc(4'h0, 16'h0000);
    endtask
    // status write in the same cycle as a flag update is dropped
    task automatic t_collide;
        @(posedge clock);
        {reg_addr, reg_wdata, upd_mask} <= {4'h0, 16'h00FF, 5'h00};
        {reg_write, upd_valid} <= 2'h3;
        @(posedge clock);
        {reg_write, upd_valid} <= 2'h0;
        rc(4'h0, 16'h0000);
    endtask
    // mid-run reset clears every register and both level outputs
    task automatic t_rerun;
        wr(4'h1, 16'h0008);
        wr(4'h0, 16'h01EF);
        wr(4'h2, 16'h8000);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        t_reset;
    endtask
    // carry chained from the held flag, pass ignores it, partial mask
    task automatic t_chain;
        op(16'hFFFF, 16'h0001, CSF_OP_ADD, CSF_SZ_WORD, 5'h1F, 5'h13);
        @(posedge clock);
        use_carry <= 1'b1;
        op(16'hFFFF, 16'h0000, CSF_OP_ADD, CSF_SZ_WORD, 5'h1F, 5'h13);
        op(16'hFFFF, 16'h0000, CSF_OP_PASS, CSF_SZ_WORD, 5'h1F, 5'h08);
        op(16'h0000, 16'h0000, CSF_OP_ADD, CSF_SZ_WORD, 5'h01, 5'h08);
        @(posedge clock);
        use_carry <= 1'b0;
    endtask

    // clock at 125 MHz
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // bound on the whole run
    initial
    begin
        repeat (5000) @(posedge clock);
        bad_count++;
        report_and_stop;
    end
    // main sequence
    initial
    begin
        {reset_n, reg_write, reg_read, upd_valid, repeat_busy} = '0;
        {use_carry, reg_addr, reg_wdata, opnd_a, opnd_b} = '0;
        op_kind = CSF_OP_ADD;
        op_size = CSF_SZ_WORD;
        upd_mask = '0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        t_reset;
        t_prio;
        t_nest;
        t_repeat;
        t_collide;
        t_rerun;
        op(16'h7FFF, 16'h0001, CSF_OP_ADD, CSF_SZ_WORD, 5'h1F, 5'h1C);
        op(16'hFFFF, 16'h0001, CSF_OP_ADD, CSF_SZ_WORD, 5'h1F, 5'h13);
        op(16'h0001, 16'h0001, CSF_OP_ADD, CSF_SZ_WORD, 5'h00, 5'h13);
        op(16'h000F, 16'h0001, CSF_OP_ADD, CSF_SZ_BYTE, 5'h1F, 5'h10);
        op(16'h0080, 16'h0001, CSF_OP_SUB, CSF_SZ_BYTE, 5'h1F, 5'h05);
        op(16'h0000, 16'h0001, CSF_OP_SUB, CSF_SZ_WORD, 5'h1F, 5'h08);
        t_chain;
        report_and_stop;
    end
endmodule // test_cpu_status_flag_logic
